// ==== rtl/cpes_pkg.sv ====
// package: constants and types of the pipeline and exception sequencer
package cpes_pkg;
  localparam int CLK_MHZ = 250;
  localparam int BUS_MIN_CLKS = 2;
  localparam int INT_OP_UNIT = 2;
  localparam logic [15:0] PC_EXEC_OFS = 16'h0006;
  localparam logic [15:0] SYNC_PC_ADJ = 16'h0002;
  localparam logic [15:0] RTE_PC_ADJ = 16'h0006;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam int VEC_TABLE_BYTES = 512;
  localparam int VEC_FIXED = 52;
  localparam int VEC_USER = 200;
  localparam int RST_VEC_WORDS = 4;
  localparam logic [15:0] RST_VEC_BASE = 16'h0000;
  localparam logic [1:0] RST_W_BANKS = 2'h0;
  localparam logic [1:0] RST_W_PC = 2'h1;
  localparam logic [1:0] RST_W_SP = 2'h2;
  localparam logic [1:0] RST_W_IZ = 2'h3;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h10;
  localparam logic [3:0] BANK_ZERO = 4'h0;
  localparam int ZK_LSB = 8;
  localparam int SK_LSB = 4;
  localparam int PK_LSB = 0;
  localparam int IPL_LSB = 5;
  localparam logic [2:0] IPL_NMI = 3'h7;
  localparam logic [15:0] CCR_RST = 16'h00E0;
  localparam logic SPACE_PROG = 1'b1;
  localparam logic SPACE_DATA = 1'b0;
  localparam logic [1:0] TRK_IDLE = 2'h3;

  typedef enum logic [2:0] {
    ST_RVEC, ST_FILL, ST_EXEC, ST_INTOP, ST_PUSH_PC, ST_PUSH_CCR, ST_VEC
  } cpes_state_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic space;
    logic [3:0] bank;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cpes_bus_t;

  typedef struct packed {
    cpes_state_t st;
    cpes_bus_t bus;
    logic bus_old;
    logic pf_own;
    logic pf_drop;
    logic [1:0] rv_idx;
    logic [3:0] pk;
    logic [3:0] sk;
    logic [3:0] zk;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] iz;
    logic [15:0] condition_code_reg;
    logic [15:0] sa;
    logic [15:0] sb;
    logic [15:0] sc;
    logic [15:0] a_addr;
    logic [15:0] b_addr;
    logic va;
    logic vb;
    logic [15:0] pf;
    logic [15:0] pf_addr;
    logic pf_v;
    logic [7:0] int_cnt;
    logic int_busy;
    logic [15:0] clk_cnt;
    logic [15:0] clk_total;
    logic exec_start;
    logic [7:0] vec;
    logic [15:0] exc_pc;
    logic [2:0] irq1;
    logic [2:0] irq2;
    logic [2:0] irq3;
    logic [2:0] irq_lvl;
    logic phase;
    logic pend_fetch;
    logic pend_start;
    logic pend_adv;
    logic pend_exc;
    logic [1:0] trk;
  } cpes_regs_t;
endpackage

// ==== rtl/cpes_seq.sv ====
// module: instruction pipeline, prefetch and exception sequencer
// Function
// [RULE1] instructions sit in a three-stage fifo, one single-word per stage
// [RULE2] fetched words enter stage a, advance to b; decode only in b
// [RULE3] operands come from stage a or b; stage b gives only 8 bits
// [RULE4] finished opcode moves b to c, stays until next one finishes
// [RULE5] prefetch bumps the counter; at start it is first word plus six
// [RULE6] flow change loads new address, old words in a and b dropped
// [RULE7] a bus cycle lasts at least two clocks, whole clocks only
// [RULE8] internal operation time is a multiple of two clocks
// [RULE9] one instruction at a time; clocks sum fetch, operand and internal
// [RULE10] vectors come from the lowest 512 bytes of bank zero
// [RULE11] normal vector is one data word; reset is four program words
// [RULE12] table has 52 fixed or reserved entries and 200 user entries
// [RULE13] 8-bit vector number shifted left once gives table address
// [RULE14] reset loads banks, counter, stack pointer, page index in order
// [RULE15] autovector levels one to seven use vectors 11 to 17 hex
// [RULE16] entry pushes counter and condition codes at the stack pointer
// [RULE17] entry: pick, stack then clear bank, get vector, load and jump
// [RULE18] non-reset vectors are 16-bit, handlers run in bank zero
// [RULE19] two multiplexed tracking outputs follow the sequencing controls
// [RULE20] asynchronous exceptions start at the next instruction boundary
// [RULE21] synchronous exceptions stack the counter plus two
// [RULE22] return subtracts six from the stacked counter before resuming
// [RULE23] after a flush stages a and b refill before the next decode
`timescale 1ns/10ps
module cpes_seq
  import cpes_pkg::*;
#(
  parameter int INT_W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_bus_ack,
  input wire logic [15:0] i_bus_rdata,
  input wire logic i_exec_done,
  input wire logic i_int_op,
  input wire logic [INT_W-1:0] i_int_pairs,
  input wire logic i_flow_chg,
  input wire logic [3:0] i_new_pk,
  input wire logic [15:0] i_new_pc,
  input wire logic i_rte,
  input wire logic [3:0] i_rte_pk,
  input wire logic [15:0] i_rte_pc,
  input wire logic [15:0] i_rte_ccr,
  input wire logic i_sync_exc,
  input wire logic [7:0] i_sync_vec,
  input wire logic [2:0] i_irq_level,
  output logic o_bus_req,
  output logic o_bus_wr,
  output logic o_bus_space,
  output logic [3:0] o_bus_bank,
  output logic [15:0] o_bus_addr,
  output logic [15:0] o_bus_wdata,
  output logic o_exec_start,
  output logic o_int_busy,
  output logic [7:0] o_opcode,
  output logic [7:0] o_opnd_b8,
  output logic [15:0] o_opnd_a,
  output logic [15:0] o_stage_c,
  output logic [15:0] o_clk_total,
  output logic [3:0] o_program_bank_ext,
  output logic [15:0] o_program_counter,
  output logic [3:0] o_stack_bank_ext,
  output logic [15:0] o_stack_pointer,
  output logic [3:0] o_z_index_bank_ext,
  output logic [15:0] o_direct_page_index,
  output logic [15:0] o_condition_code_reg,
  output logic o_pipe_track_out0,
  output logic o_pipe_track_out1
);
  cpes_regs_t r_q, r_d;
  logic bd, own_bd, pf_ok, irq_take, flush;
  logic ev_fetch, ev_start, ev_adv, ev_exc;
  logic [INT_W:0] int_len;
  logic [15:0] nxt;
  logic [8:0] int_run;
  if (INT_W < 1 || INT_W > 7) begin : g_chk_w
    $error("INT_W must be 1 to 7");
  end
  // whole table is 256 two-byte entries
  if ((VEC_FIXED + VEC_USER + RST_VEC_WORDS) * 2 != VEC_TABLE_BYTES)
  begin : g_chk_tab // [RULE12]
    $error("vector table size mismatch");
  end
  function automatic cpes_bus_t mk_bus(input logic wr, input logic spc,
    input logic [3:0] bk, input logic [15:0] ad, input logic [15:0] wd);
    cpes_bus_t b;
    b = '{req: 1'b1, wr: wr, space: spc, bank: bk, addr: ad, wdata: wd};
    return b;
  endfunction
  always_comb begin
    r_d = r_q;
    ev_fetch = 1'b0;
    ev_start = 1'b0;
    ev_adv = 1'b0;
    ev_exc = 1'b0;
    flush = 1'b0;
    nxt = r_q.b_addr + WORD_STEP;
    int_len = {i_int_pairs, 1'b0};
    r_d.exec_start = 1'b0;
    // done only after the first request clock has passed
    bd = r_q.bus.req && r_q.bus_old && i_bus_ack; // [RULE7]
    own_bd = bd && !r_q.pf_own;
    irq_take = (r_q.irq_lvl != 3'h0) && ((r_q.irq_lvl == IPL_NMI)
      || (r_q.irq_lvl > r_q.condition_code_reg[IPL_LSB +: 3]));
    pf_ok = (r_q.st == ST_FILL || r_q.st == ST_EXEC || r_q.st == ST_INTOP)
      && !r_q.bus.req && !r_q.pf_v;
    r_d.bus_old = r_q.bus.req;
    if (bd) begin
      r_d.bus.req = 1'b0;
      r_d.bus_old = 1'b0;
      r_d.pf_own = 1'b0;
    end
    // level pin synchroniser, change taken when stages two and three agree
    r_d.irq1 = i_irq_level;
    r_d.irq2 = r_q.irq1;
    r_d.irq3 = r_q.irq2;
    if (r_q.irq2 == r_q.irq3) begin
      r_d.irq_lvl = r_q.irq3;
    end
    // prefetched word lands, unless its stream was flushed
    if (bd && r_q.pf_own) begin
      if (!r_q.pf_drop) begin
        r_d.pf = i_bus_rdata;
        r_d.pf_v = 1'b1;
      end
      r_d.pf_drop = 1'b0;
    end
    unique case (r_q.st)
      ST_RVEC: begin
        if (!r_q.bus.req) begin // [RULE11]
          r_d.bus = mk_bus(1'b0, SPACE_PROG, BANK_ZERO,
            RST_VEC_BASE + {13'h0, r_q.rv_idx, 1'b0}, 16'h0000);
        end
        if (own_bd) begin // [RULE14]
          unique case (r_q.rv_idx)
            RST_W_BANKS: begin
              r_d.zk = i_bus_rdata[ZK_LSB +: 4];
              r_d.sk = i_bus_rdata[SK_LSB +: 4];
              r_d.pk = i_bus_rdata[PK_LSB +: 4];
            end
            RST_W_PC: r_d.pc = i_bus_rdata;
            RST_W_SP: r_d.sp = i_bus_rdata;
            RST_W_IZ: begin
              r_d.iz = i_bus_rdata;
              r_d.st = ST_FILL;
            end
          endcase
          r_d.rv_idx = r_q.rv_idx + 2'h1;
        end
      end
      ST_FILL: begin
        if (r_q.pf_v && !(r_q.va && r_q.vb)) begin // [RULE1] [RULE2]
          if (r_q.va) begin
            r_d.sb = r_q.sa;
            r_d.b_addr = r_q.a_addr;
            r_d.vb = 1'b1;
          end
          r_d.sa = r_q.pf;
          r_d.a_addr = r_q.pf_addr;
          r_d.va = 1'b1;
          r_d.pf_v = 1'b0;
        end else if (r_q.va && r_q.vb && pf_ok) begin // [RULE23]
          r_d.st = ST_EXEC;
          r_d.exec_start = 1'b1;
          r_d.clk_cnt = 16'h0000;
          ev_start = 1'b1;
        end
      end
      ST_EXEC: begin
        r_d.clk_cnt = r_q.clk_cnt + 16'h0001;
        if (i_int_op && i_int_pairs != '0) begin // [RULE8]
          r_d.st = ST_INTOP;
          r_d.int_cnt = 8'(int_len) - 8'h01;
          r_d.int_busy = 1'b1;
        end else if (i_exec_done) begin
          r_d.clk_total = r_q.clk_cnt + 16'h0001; // [RULE9]
          r_d.sc = r_q.sb; // [RULE4]
          r_d.vb = 1'b0;
          ev_adv = 1'b1;
          if (r_q.va) begin
            r_d.sb = r_q.sa;
            r_d.b_addr = r_q.a_addr;
            r_d.vb = 1'b1;
            r_d.va = 1'b0;
          end
          if (r_q.pf_v) begin
            r_d.sa = r_q.pf;
            r_d.a_addr = r_q.pf_addr;
            r_d.va = 1'b1;
            r_d.pf_v = 1'b0;
          end
          r_d.st = ST_FILL;
          if (i_rte) begin
            r_d.pc = i_rte_pc - RTE_PC_ADJ; // [RULE22]
            r_d.pk = i_rte_pk;
            r_d.condition_code_reg = i_rte_ccr;
            nxt = i_rte_pc - RTE_PC_ADJ;
            flush = 1'b1;
          end else if (i_flow_chg) begin
            r_d.pc = i_new_pc; // [RULE6]
            r_d.pk = i_new_pk;
            nxt = i_new_pc;
            flush = 1'b1;
          end
          // asynchronous ranks above synchronous, taken at the boundary
          if (irq_take) begin // [RULE17] [RULE20]
            r_d.vec = VEC_AUTO_BASE + {5'h00, r_q.irq_lvl}; // [RULE15]
            r_d.exc_pc = nxt + PC_EXEC_OFS; // [RULE16]
            r_d.st = ST_PUSH_PC;
            ev_exc = 1'b1;
            flush = 1'b1;
          end else if (i_sync_exc) begin
            r_d.vec = i_sync_vec;
            r_d.exc_pc = r_q.b_addr + PC_EXEC_OFS + SYNC_PC_ADJ; // [RULE21]
            r_d.st = ST_PUSH_PC;
            ev_exc = 1'b1;
            flush = 1'b1;
          end
        end
      end
      ST_INTOP: begin
        r_d.clk_cnt = r_q.clk_cnt + 16'h0001;
        if (r_q.int_cnt == 8'h00) begin
          r_d.st = ST_EXEC;
          r_d.int_busy = 1'b0;
        end else begin
          r_d.int_cnt = r_q.int_cnt - 8'h01;
        end
      end
      ST_PUSH_PC: begin
        if (!r_q.bus.req) begin // [RULE16]
          r_d.bus = mk_bus(1'b1, SPACE_DATA, r_q.sk, r_q.sp, r_q.exc_pc);
        end
        if (own_bd) begin
          r_d.sp = r_q.sp - WORD_STEP;
          r_d.st = ST_PUSH_CCR;
        end
      end
      ST_PUSH_CCR: begin
        if (!r_q.bus.req) begin
          r_d.bus = mk_bus(1'b1, SPACE_DATA, r_q.sk, r_q.sp, r_q.condition_code_reg);
        end
        if (own_bd) begin // [RULE17]
          r_d.sp = r_q.sp - WORD_STEP;
          r_d.pk = BANK_ZERO;
          r_d.st = ST_VEC;
        end
      end
      ST_VEC: begin
        if (!r_q.bus.req) begin // [RULE10] [RULE13]
          r_d.bus = mk_bus(1'b0, SPACE_DATA, BANK_ZERO,
            {7'h00, r_q.vec, 1'b0}, 16'h0000);
        end
        if (own_bd) begin // [RULE18]
          r_d.pc = i_bus_rdata;
          r_d.pk = BANK_ZERO;
          r_d.st = ST_FILL;
        end
      end
    endcase
    if (flush) begin // [RULE6]
      r_d.va = 1'b0;
      r_d.vb = 1'b0;
      r_d.pf_v = 1'b0;
      r_d.pf_drop = r_q.bus.req && r_q.pf_own && !bd;
    end else if (pf_ok) begin // [RULE5]
      r_d.bus = mk_bus(1'b0, SPACE_PROG, r_q.pk, r_q.pc, 16'h0000);
      r_d.pf_own = 1'b1;
      r_d.pf_addr = r_q.pc;
      r_d.pc = r_q.pc + WORD_STEP;
      ev_fetch = 1'b1;
    end
    // two phases: fetch and start, then exception and advance
    r_d.phase = !r_q.phase; // [RULE19]
    r_d.pend_fetch = (r_q.pend_fetch && r_q.phase) || ev_fetch;
    r_d.pend_start = (r_q.pend_start && r_q.phase) || ev_start;
    r_d.pend_adv = (r_q.pend_adv && !r_q.phase) || ev_adv;
    r_d.pend_exc = (r_q.pend_exc && !r_q.phase) || ev_exc;
    if (!r_q.phase) begin
      r_d.trk = {!r_q.pend_start, !r_q.pend_fetch};
    end else begin
      r_d.trk = {!r_q.pend_exc, !r_q.pend_adv};
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_q <= '0;
      r_q.condition_code_reg <= CCR_RST;
      r_q.trk <= TRK_IDLE;
    end else if (i_ce) begin
      r_q <= r_d;
    end
  end
  assign o_bus_req = r_q.bus.req;
  assign o_bus_wr = r_q.bus.wr;
  assign o_bus_space = r_q.bus.space;
  assign o_bus_bank = r_q.bus.bank;
  assign o_bus_addr = r_q.bus.addr;
  assign o_bus_wdata = r_q.bus.wdata;
  assign o_exec_start = r_q.exec_start;
  assign o_int_busy = r_q.int_busy;
  assign o_opcode = r_q.sb[15:8];
  assign o_opnd_b8 = r_q.sb[7:0]; // [RULE3]
  assign o_opnd_a = r_q.sa;
  assign o_stage_c = r_q.sc;
  assign o_clk_total = r_q.clk_total;
  assign o_program_bank_ext = r_q.pk;
  assign o_program_counter = r_q.pc;
  assign o_stack_bank_ext = r_q.sk;
  assign o_stack_pointer = r_q.sp;
  assign o_z_index_bank_ext = r_q.zk;
  assign o_direct_page_index = r_q.iz;
  assign o_condition_code_reg = r_q.condition_code_reg;
  assign o_pipe_track_out0 = r_q.trk[0];
  assign o_pipe_track_out1 = r_q.trk[1];
  // helper: length of the current internal operation run
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      int_run <= 9'h000;
    end else if (i_ce) begin
      int_run <= r_q.int_busy ? int_run + 9'h001 : 9'h000;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  chk_bus_two_clk: assert property ( // [RULE7]
    $rose(r_q.bus.req) |-> ##1 r_q.bus.req && $stable(r_q.bus))
    else $error("bus cycle shorter than two clocks");
  chk_pc_at_start: assert property ( // [RULE5]
    r_q.exec_start |-> r_q.pc == r_q.b_addr + PC_EXEC_OFS)
    else $error("counter not first word plus six at start");
  chk_stages_full: assert property ( // [RULE23]
    r_q.exec_start |-> r_q.va && r_q.vb && r_q.st == ST_EXEC)
    else $error("execution began with empty stage");
  chk_stage_c_move: assert property ( // [RULE4]
    i_ce && r_q.st == ST_EXEC && i_exec_done && !i_int_op
    |=> r_q.sc == $past(r_q.sb))
    else $error("stage c not loaded from stage b");
  chk_intop_even: assert property ( // [RULE8]
    $fell(r_q.int_busy) |-> int_run[0] == 1'b0 && int_run != 9'h000)
    else $error("internal operation not a multiple of two");
  chk_rst_pc_load: assert property ( // [RULE14]
    i_ce && r_q.st == ST_RVEC && own_bd && r_q.rv_idx == RST_W_PC
    |=> r_q.pc == $past(i_bus_rdata) && r_q.rv_idx == RST_W_SP)
    else $error("reset counter word misplaced");
  chk_vec_fetch: assert property ( // [RULE13]
    r_q.st == ST_VEC && r_q.bus.req |-> r_q.bus.addr == {7'h00, r_q.vec,
    1'b0} && r_q.bus.bank == BANK_ZERO && r_q.bus.space == SPACE_DATA)
    else $error("vector fetch address wrong");
  chk_pk_cleared: assert property ( // [RULE18]
    r_q.st == ST_VEC || $past(r_q.st) == ST_VEC |-> r_q.pk == BANK_ZERO)
    else $error("program bank not cleared for handler");
  chk_rte_adjust: assert property ( // [RULE22]
    i_ce && r_q.st == ST_EXEC && i_exec_done && !i_int_op && i_rte
    && !irq_take && !i_sync_exc |=> r_q.pc == $past(i_rte_pc) - RTE_PC_ADJ)
    else $error("return counter not reduced by six");
  chk_push_order: assert property ( // [RULE17]
    $rose(r_q.st == ST_VEC) |-> $past(r_q.st) == ST_PUSH_CCR)
    else $error("vector fetched before stacking");
  cov_reset_done: cover property ($fell(r_q.st == ST_RVEC));
  cov_irq_entry: cover property (ev_exc && irq_take && i_ce);
  cov_flow_flush: cover property (flush && i_flow_chg && i_ce);
endmodule

// ==== sim/cpes_mem.sv ====
// memory partner model answering the sequencer's bus requests
`timescale 1ns/10ps
module cpes_mem
  import cpes_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire cpes_bus_t i_bus,
  output logic o_ack,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [logic [20:0]];
  cpes_bus_t log_q[$];
  cpes_bus_t held;
  cpes_bus_t ent;
  logic [20:0] key;
  int wait_n = 0;
  int viol = 0;
  int cnt = 0;

  // answer from the second request clock on, later when slowed
  always @(posedge i_clk) begin
    key = {i_bus.space, i_bus.bank, i_bus.addr};
    if (i_rst) begin
      o_ack <= 1'b0;
      o_rdata <= 16'h0000;
      cnt = 0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      cnt = 0;
    end else if (i_bus.req) begin
      if (cnt > 0 && i_bus !== held) viol++; // request must stand
      held = i_bus;
      if (cnt >= wait_n) begin // slow memory lengthens the cycle
        ent = i_bus;
        if (i_bus.wr) mem[key] = i_bus.wdata;
        else if (mem.exists(key)) ent.wdata = mem[key];
        else ent.wdata = i_bus.addr;
        o_rdata <= ent.wdata;
        o_ack <= 1'b1;
        log_q.push_back(ent);
      end
      cnt++;
    end else begin
      if (cnt > 0) viol++; // dropped before the answer
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// ==== sim/testbench.sv ====
// self-checking bench of the pipeline and exception sequencer
`timescale 1ns/10ps
module testbench;
  import cpes_pkg::*;
  logic i_clk, i_rst, i_exec_done, i_int_op, i_flow_chg, i_rte, i_sync_exc;
  logic [3:0] i_int_pairs, i_new_pk, i_rte_pk;
  logic [15:0] i_new_pc, i_rte_pc, i_rte_ccr, i_bus_rdata;
  logic [7:0] i_sync_vec, o_opcode, o_opnd_b8;
  logic [2:0] i_irq_level;
  logic i_bus_ack, o_bus_req, o_bus_wr, o_bus_space, o_exec_start;
  logic o_int_busy, o_pipe_track_out0, o_pipe_track_out1, i_ce;
  logic [3:0] o_bus_bank, o_program_bank_ext, o_stack_bank_ext;
  logic [3:0] o_z_index_bank_ext;
  logic [15:0] o_bus_addr, o_bus_wdata, o_opnd_a, o_stage_c, o_clk_total;
  logic [15:0] o_program_counter, o_stack_pointer, o_direct_page_index;
  logic [15:0] o_condition_code_reg, exp_b, t1;
  logic [3:0] exp_pk;
  cpes_bus_t bus;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;

  assign bus = {o_bus_req, o_bus_wr, o_bus_space, o_bus_bank, o_bus_addr,
                o_bus_wdata};

  cpes_seq dut (.i_clk, .i_rst, .i_ce, .i_bus_ack, .i_bus_rdata,
    .i_exec_done, .i_int_op, .i_int_pairs, .i_flow_chg, .i_new_pk,
    .i_new_pc, .i_rte, .i_rte_pk, .i_rte_pc, .i_rte_ccr, .i_sync_exc,
    .i_sync_vec, .i_irq_level, .o_bus_req, .o_bus_wr, .o_bus_space,
    .o_bus_bank, .o_bus_addr, .o_bus_wdata, .o_exec_start, .o_int_busy,
    .o_opcode, .o_opnd_b8, .o_opnd_a, .o_stage_c, .o_clk_total,
    .o_program_bank_ext, .o_program_counter, .o_stack_bank_ext,
    .o_stack_pointer, .o_z_index_bank_ext, .o_direct_page_index,
    .o_condition_code_reg, .o_pipe_track_out0, .o_pipe_track_out1);

  cpes_mem u_mem (.i_clk, .i_rst, .i_bus(bus), .o_ack(i_bus_ack),
    .o_rdata(i_bus_rdata));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task give_verdict();
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // wait for a decode start and compare the pipeline view
  task automatic start_chk();
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge i_clk);
      #1;
      if (o_exec_start === 1'b1) break;
    end
    chk({15'h0, o_exec_start}, 16'h0001);
    chk({o_opcode, o_opnd_b8}, exp_b);
    chk(o_opnd_a, exp_b + WORD_STEP);
    chk(o_program_counter, exp_b + PC_EXEC_OFS);
    chk({12'h0, o_program_bank_ext}, {12'h0, exp_pk});
  endtask

  task automatic done(input logic fl, input logic sy, input logic rt,
                      input logic [7:0] v);
    @(posedge i_clk);
    i_exec_done <= 1'b1;
    i_flow_chg <= fl;
    i_sync_exc <= sy;
    i_rte <= rt;
    i_sync_vec <= v;
    @(posedge i_clk);
    i_exec_done <= 1'b0;
    i_flow_chg <= 1'b0;
    i_sync_exc <= 1'b0;
    i_rte <= 1'b0;
    i_irq_level <= 3'h0;
  endtask

  task automatic int_op(input logic [3:0] p);
    int n;
    int k;
    @(posedge i_clk);
    i_int_op <= 1'b1;
    i_int_pairs <= p;
    @(posedge i_clk);
    i_int_op <= 1'b0;
    n = 0;
    for (k = 0; k < 40; k++) begin
      #1;
      if (o_int_busy === 1'b1) n++;
      else if (n > 0) break;
      @(posedge i_clk);
    end
    chk(16'(n), {11'h0, p, 1'b0});
  endtask

  // exception at the boundary: stack frame, vector read, handler entry
  task automatic exc(input logic sy, input logic [7:0] v,
                     input logic [15:0] va, input logic [15:0] h);
    logic [15:0] sp0, cc0, ret;
    logic [3:0] sk0;
    cpes_bus_t e;
    int k;
    int wi;
    int rd;
    sp0 = o_stack_pointer;
    cc0 = o_condition_code_reg;
    sk0 = o_stack_bank_ext;
    ret = exp_b + 16'h0008;
    wi = 0;
    rd = 0;
    u_mem.log_q.delete();
    done(1'b0, sy, 1'b0, v);
    exp_b = h;
    exp_pk = BANK_ZERO;
    start_chk();
    for (k = 0; k < u_mem.log_q.size(); k++) begin
      e = u_mem.log_q[k];
      if (e.wr) begin
        chk(e.addr, sp0 - 16'(2 * wi));
        chk(e.wdata, (wi == 0) ? ret : cc0);
        chk({12'h0, e.bank}, {12'h0, sk0});
        wi++;
      end else if (e.space == SPACE_DATA) begin
        chk(e.addr, va);
        chk({12'h0, e.bank}, {12'h0, BANK_ZERO});
        chk(16'(wi), 16'h0002);
        rd++;
      end
    end
    chk(16'(rd), 16'h0001);
    chk(o_stack_pointer, sp0 - 16'h0004);
  endtask

  task automatic t_boot();
    int j;
    logic seen;
    u_mem.mem[{SPACE_PROG, BANK_ZERO, 16'h0000}] = 16'h0321;
    u_mem.mem[{SPACE_PROG, BANK_ZERO, 16'h0002}] = 16'h0100;
    u_mem.mem[{SPACE_PROG, BANK_ZERO, 16'h0004}] = 16'h0800;
    u_mem.mem[{SPACE_PROG, BANK_ZERO, 16'h0006}] = 16'h4000;
    u_mem.mem[{SPACE_DATA, BANK_ZERO, 16'h000C}] = 16'h0200;
    u_mem.mem[{SPACE_DATA, BANK_ZERO, 16'h01FE}] = 16'h0600;
    for (j = 1; j < 8; j++) begin
      u_mem.mem[{SPACE_DATA, BANK_ZERO, 16'h0020 + 16'(2 * j)}] =
        16'h0500 + 16'(j << 4);
    end
    repeat (2) @(posedge i_clk);
    #1;
    t1 = {14'h0, o_pipe_track_out1, o_pipe_track_out0};
    chk(t1, 16'(TRK_IDLE));
    chk({15'h0, o_bus_req}, 16'h0000);
    @(posedge i_clk);
    i_rst <= 1'b0;
    exp_b = 16'h0100;
    exp_pk = 4'h1;
    start_chk();
    for (j = 0; j < RST_VEC_WORDS; j++) begin
      chk({u_mem.log_q[j].space, 11'h0, u_mem.log_q[j].bank},
          {SPACE_PROG, 11'h0, BANK_ZERO});
      chk(u_mem.log_q[j].addr, 16'(2 * j));
    end
    chk({4'h0, o_z_index_bank_ext, o_stack_bank_ext, o_program_bank_ext},
        16'h0321);
    chk(o_stack_pointer, 16'h0800);
    chk(o_direct_page_index, 16'h4000);
    chk(o_condition_code_reg, CCR_RST);
    seen = 1'b0;
    for (j = 0; j < 4; j++) begin
      if (o_pipe_track_out1 === 1'b0) seen = 1'b1;
      @(posedge i_clk);
      #1;
    end
    chk({15'h0, seen}, 16'h0001);
  endtask

  task automatic t_adv();
    int i;
    for (i = 0; i < 3; i++) begin
      if (i > 0) int_op(4'(2 * i - 1));
      done(1'b0, 1'b0, 1'b0, 8'h00);
      exp_b = exp_b + WORD_STEP;
      start_chk();
      chk(o_stage_c, exp_b - WORD_STEP);
      if (i == 2) chk(o_clk_total - t1, 16'h0004);
      t1 = o_clk_total;
    end
  endtask

  // clock enable low freezes all state, here an internal operation
  task automatic t_hold();
    @(posedge i_clk);
    i_int_op <= 1'b1;
    i_int_pairs <= 4'h1;
    @(posedge i_clk);
    i_int_op <= 1'b0;
    i_ce <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    chk({15'h0, o_int_busy}, 16'h0001);
    @(posedge i_clk);
    i_ce <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    chk({15'h0, o_int_busy}, 16'h0000);
  endtask

  task automatic t_flow();
    u_mem.wait_n = 2;
    @(posedge i_clk);
    i_new_pk <= 4'h2;
    i_new_pc <= 16'h0400;
    done(1'b1, 1'b0, 1'b0, 8'h00);
    exp_b = 16'h0400;
    exp_pk = 4'h2;
    start_chk();
    u_mem.wait_n = 0;
  endtask

  task automatic t_irq();
    int l;
    logic [15:0] va_l;
    for (l = 1; l < 8; l++) begin
      @(posedge i_clk);
      i_rte_pk <= 4'(l);
      i_rte_pc <= 16'h1006 + 16'(l << 4);
      i_rte_ccr <= 16'h0000;
      done(1'b0, 1'b0, 1'b1, 8'h00);
      exp_b = 16'h1000 + 16'(l << 4);
      exp_pk = 4'(l);
      start_chk();
      chk(o_condition_code_reg, 16'h0000);
      @(posedge i_clk);
      i_irq_level <= 3'(l);
      repeat (6) @(posedge i_clk);
      va_l = 16'h0020 + 16'(2 * l);
      exc(1'b0, 8'h00, va_l, 16'h0500 + 16'(l << 4));
    end
  endtask

  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    {i_exec_done, i_int_op, i_flow_chg, i_rte, i_sync_exc} = 5'h00;
    {i_int_pairs, i_new_pk, i_rte_pk} = 12'h000;
    {i_new_pc, i_rte_pc, i_rte_ccr} = 48'h0;
    i_sync_vec = 8'h00;
    i_irq_level = 3'h0;
    t_boot();
    t_adv();
    t_hold();
    t_flow();
    exc(1'b1, 8'h06, 16'h000C, 16'h0200);
    exc(1'b1, 8'hFF, 16'h01FE, 16'h0600);
    t_irq();
    chk(16'(u_mem.viol), 16'h0000);
    give_verdict();
  end
endmodule
